// file: tll_pkg.sv
// constants, offsets and carrier types for the target indicator block
`default_nettype none
package tll_pkg;
   localparam int unsigned NUM_TGT      = 6;          // programmable target indicators
   localparam int unsigned ROW_BITS     = 8;          // status bits per target row
   localparam int unsigned CLK_PERIOD_NS = 5;         // MCLK period
   localparam int unsigned PROC_NS      = 1000;       // processing interval
   localparam int unsigned PROC_CYC     = (PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BLINK_US     = 250000;     // half period of the warning flash
   localparam int unsigned BLINK_TICKS  = BLINK_US * 1000 / PROC_NS;
   // register byte offsets
   localparam logic [7:0] OFS_CFG   = 8'h00;          // latch selects and warning enables
   localparam logic [7:0] OFS_CMD   = 8'h04;          // target reset command
   localparam logic [7:0] OFS_STAT  = 8'h08;          // indicator and message state
   localparam logic [7:0] OFS_VIEW  = 8'h0C;          // row view with pair select
   localparam logic [7:0] OFS_ISTAT = 8'h10;          // sticky events, write one to clear
   localparam logic [7:0] OFS_IMASK = 8'h14;          // event mask
   // field positions
   localparam int unsigned CFG_WEN_POS = 8;           // warning enables at [13:8]
   localparam int unsigned NUM_WARN    = 6;
   localparam int unsigned EV_TRIP     = 0;           // event bits
   localparam int unsigned EV_WARN     = 1;
   localparam int unsigned EV_RESET    = 2;
   localparam int unsigned NUM_EV      = 3;
   // values after reset
   localparam logic [5:0]  RST_LATCH_SEL = 6'h3F;
   localparam logic [5:0]  RST_WARN_EN   = 6'h3F;
   localparam logic [2:0]  RST_IMASK     = 3'h0;
   localparam logic [1:0]  RST_PAIR      = 2'h0;
   // warning flags from the protection logic
   typedef struct packed {
      logic arc_flash_alarm;
      logic power_factor_alarm;
      logic winding_temp_alarm;
      logic bearing_temp_alarm;
      logic ambient_temp_alarm;
      logic other_temp_alarm;
      logic temp_sensor_fault;
      logic comm_loss_flag;
      logic comm_idle_flag;
   } tll_warn_t;
   // front-panel indicator drive
   typedef struct packed {
      logic       enabled;
      logic       trip;
      logic [5:0] target;
   } tll_led_t;
endpackage
`default_nettype wire

// file: tll_target_leds.sv
// target indicator latch, reset, lamp test and warning flash with wishbone registers
// How it works
// - six target indicators, each with its own assertion equation and latch select
// - unlatched indicator follows its assertion equation directly
// - latched indicator lights only if tripped while its equation is true, then holds
// - reset clears a latched indicator only if its condition is gone
// - a trip latches all involved targets whose latch select is set, never the enabled indicator
// - a new trip drops older unreset latched targets, showing only the new ones
// - holding the reset button lights every indicator as lamp test
// - button release turns off latched targets whose conditions cleared
// - button release relights targets whose conditions are still present
// - reset clears the pending trip message only when the trip has cleared
// - the target reset equation resets targets like the button
// - trip indicator flashes while any enabled warning is active and no trip is present or latched
// - trip indicator lights on every trip and is not reassignable
// - enabled indicator shows healthy self-test and is not reprogrammable
// - status rows of eight bits, shown two consecutive bits at a time
`default_nettype none
module tll_target_leds #(
   parameter int unsigned BLINK_LEN = tll_pkg::BLINK_TICKS
) (
   input  wire logic              MCLK,
   input  wire logic              RSTN,
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [7:0]        WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic      [31:0]       WB_DAT_O,
   output logic                   WB_ACK_O,
   input  wire logic [5:0]        LED_ASSERT_EQUATION,
   input  wire logic              TRIP_IN,
   input  wire logic              SELF_TEST_OK,
   input  wire tll_pkg::tll_warn_t WARN_IN,
   input  wire logic              TARGET_RESET_EQUATION,
   input  wire logic              RESET_BUTTON,
   output tll_pkg::tll_led_t      LED_OUT,
   output logic                   TRIP_MSG,
   output logic      [1:0]        DISP_PAIR,
   output logic                   IRQ
);
   import tll_pkg::*;

   // pushbutton synchroniser
   logic       btn_m_q, btn_s_q;
   // processing interval divider and flash timer
   logic [15:0] div_q, div_d;
   logic [31:0] blk_cnt_q, blk_cnt_d;
   logic        blink_q, blink_d;
   logic        tick;
   // sampled state
   logic [5:0] asrt_q, asrt_d;
   logic       trip_prev_q, trip_prev_d;
   logic       btn_prev_q, btn_prev_d;
   logic [5:0] lat_q, lat_d;
   logic       trip_lat_q, trip_lat_d;
   logic       msg_q, msg_d;
   logic       warn_q, warn_d;
   logic       cmd_pend_q, cmd_pend_d;
   // registers
   logic [5:0] sel_q, sel_d;
   logic [5:0] wen_q, wen_d;
   logic [1:0] pair_q, pair_d;
   logic [2:0] ist_q, ist_d;
   logic [2:0] imask_q, imask_d;
   // bus
   logic        ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   // outputs
   tll_led_t   led_q, led_d;
   logic [1:0] disp_q, disp_d;
   logic       irq_q, irq_d;
   // events
   logic       trip_rise, rst_req, warn_now;
   logic [5:0] warn_vec;
   logic [7:0] row;
   logic       bus_req, wr_hit;

   // two flops on the button pin before any logic reads it
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         btn_m_q <= 1'b0;
         btn_s_q <= 1'b0;
      end else begin
         btn_m_q <= RESET_BUTTON;
         btn_s_q <= btn_m_q;
      end
   end

   // warning sources gated by their enables, temperature alarms merged
   always_comb begin
      warn_vec = {WARN_IN.arc_flash_alarm, WARN_IN.power_factor_alarm,
                  WARN_IN.winding_temp_alarm | WARN_IN.bearing_temp_alarm |
                  WARN_IN.ambient_temp_alarm | WARN_IN.other_temp_alarm,
                  WARN_IN.temp_sensor_fault, WARN_IN.comm_loss_flag, WARN_IN.comm_idle_flag};
      warn_now = |(warn_vec & wen_q);
   end

   // interval divider and flash timer
   assign tick = (div_q == 16'h0000);
   always_comb begin
      div_d     = tick ? 16'(PROC_CYC - 1) : 16'(div_q - 16'h0001);
      blk_cnt_d = blk_cnt_q;
      blink_d   = blink_q;
      if (tick) begin
         if (blk_cnt_q >= BLINK_LEN - 1) begin
            blk_cnt_d = 32'h0000_0000;
            blink_d   = ~blink_q;
         end else begin
            blk_cnt_d = blk_cnt_q + 32'h0000_0001;
         end
      end
   end

   // reset sources and trip edge, looked at only on the interval tick
   assign trip_rise = TRIP_IN & ~trip_prev_q;
   assign rst_req   = TARGET_RESET_EQUATION | cmd_pend_q | (btn_prev_q & ~btn_s_q);

   // latch and message next state
   always_comb begin
      asrt_d      = asrt_q;
      trip_prev_d = trip_prev_q;
      btn_prev_d  = btn_prev_q;
      lat_d       = lat_q;
      trip_lat_d  = trip_lat_q;
      msg_d       = msg_q;
      warn_d      = warn_q;
      if (tick) begin
         asrt_d      = LED_ASSERT_EQUATION;
         trip_prev_d = TRIP_IN;
         btn_prev_d  = btn_s_q;
         warn_d      = warn_now;
         if (trip_rise) begin
            lat_d      = LED_ASSERT_EQUATION & sel_q;
            trip_lat_d = 1'b1;
            msg_d      = 1'b1;
         end else if (rst_req) begin
            lat_d = lat_q & LED_ASSERT_EQUATION;
            if (!TRIP_IN) begin
               trip_lat_d = 1'b0;
               msg_d      = 1'b0;
            end
         end
      end
   end

   // bus decode and register writes
   assign bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
   assign wr_hit  = bus_req & WB_WE_I;
   always_comb begin
      sel_d      = sel_q;
      wen_d      = wen_q;
      pair_d     = pair_q;
      imask_d    = imask_q;
      cmd_pend_d = tick ? 1'b0 : cmd_pend_q;
      ist_d      = ist_q;
      if (wr_hit && WB_SEL_I[0]) begin
         case (WB_ADR_I)
            OFS_CFG:   sel_d   = WB_DAT_I[5:0];
            OFS_CMD:   cmd_pend_d = cmd_pend_d | WB_DAT_I[0];
            OFS_VIEW:  pair_d  = WB_DAT_I[1:0];
            OFS_ISTAT: ist_d   = ist_q & ~WB_DAT_I[2:0];
            OFS_IMASK: imask_d = WB_DAT_I[2:0];
            default:   ;
         endcase
      end
      if (wr_hit && WB_SEL_I[1] && WB_ADR_I == OFS_CFG) begin
         wen_d = WB_DAT_I[CFG_WEN_POS +: NUM_WARN];
      end
      // hardware set wins over a same-cycle clear
      if (tick && trip_rise) begin
         ist_d[EV_TRIP] = 1'b1;
      end
      if (tick && warn_now && !warn_q) begin
         ist_d[EV_WARN] = 1'b1;
      end
      if (tick && !trip_rise && rst_req) begin
         ist_d[EV_RESET] = 1'b1;
      end
   end

   // status row: enabled, trip, six targets
   assign row = {led_q.enabled, led_q.trip, led_q.target};

   // read data and acknowledge, one wait state
   always_comb begin
      ack_d  = bus_req;
      rdat_d = 32'h0000_0000;
      if (bus_req && !WB_WE_I) begin
         case (WB_ADR_I)
            OFS_CFG:   rdat_d = {18'h00000, wen_q, 2'h0, sel_q};
            OFS_STAT:  rdat_d = {22'h000000, msg_q, warn_q, row};
            OFS_VIEW:  rdat_d = {20'h00000, 2'(row[2*pair_q +: 2]), pair_q, row};
            OFS_ISTAT: rdat_d = {29'h00000000, ist_q};
            OFS_IMASK: rdat_d = {29'h00000000, imask_q};
            default:   rdat_d = 32'h0000_0000;
         endcase
      end
   end

   // indicator drive, lamp test overrides everything
   always_comb begin
      led_d.enabled = SELF_TEST_OK;
      led_d.trip    = TRIP_IN | trip_lat_q | (warn_q & blink_q);
      for (int i = 0; i < NUM_TGT; i++) begin
         led_d.target[i] = sel_q[i] ? lat_q[i] : asrt_q[i];
      end
      if (btn_s_q) begin
         led_d = '1;
      end
      disp_d = row[2*pair_q +: 2];
      irq_d  = |(ist_q & imask_q);
   end

   // state registers
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         div_q       <= 16'h0000;
         blk_cnt_q   <= 32'h0000_0000;
         blink_q     <= 1'b0;
         asrt_q      <= 6'h00;
         trip_prev_q <= 1'b0;
         btn_prev_q  <= 1'b0;
         lat_q       <= 6'h00;
         trip_lat_q  <= 1'b0;
         msg_q       <= 1'b0;
         warn_q      <= 1'b0;
         cmd_pend_q  <= 1'b0;
         sel_q       <= RST_LATCH_SEL;
         wen_q       <= RST_WARN_EN;
         pair_q      <= RST_PAIR;
         ist_q       <= 3'h0;
         imask_q     <= RST_IMASK;
         ack_q       <= 1'b0;
         rdat_q      <= 32'h0000_0000;
         led_q       <= '0;
         disp_q      <= 2'h0;
         irq_q       <= 1'b0;
      end else begin
         div_q       <= div_d;
         blk_cnt_q   <= blk_cnt_d;
         blink_q     <= blink_d;
         asrt_q      <= asrt_d;
         trip_prev_q <= trip_prev_d;
         btn_prev_q  <= btn_prev_d;
         lat_q       <= lat_d;
         trip_lat_q  <= trip_lat_d;
         msg_q       <= msg_d;
         warn_q      <= warn_d;
         cmd_pend_q  <= cmd_pend_d;
         sel_q       <= sel_d;
         wen_q       <= wen_d;
         pair_q      <= pair_d;
         ist_q       <= ist_d;
         imask_q     <= imask_d;
         ack_q       <= ack_d;
         rdat_q      <= rdat_d;
         led_q       <= led_d;
         disp_q      <= disp_d;
         irq_q       <= irq_d;
      end
   end

   assign WB_ACK_O  = ack_q;
   assign WB_DAT_O  = rdat_q;
   assign LED_OUT   = led_q;
   assign TRIP_MSG  = msg_q;
   assign DISP_PAIR = disp_q;
   assign IRQ       = irq_q;

   // checks on the latch and indicator behaviour
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   sequence s_trip_taken;
      tick && trip_rise;
   endsequence
   sequence s_reset_taken;
      tick && !trip_rise && rst_req;
   endsequence

   property p_follow;
      !btn_s_q && !sel_q[0] |=> LED_OUT.target[0] == $past(asrt_q[0]);
   endproperty
   a_follow: assert property (p_follow) else $error("unlatched target not following");

   property p_trip_latch;
      s_trip_taken |=> lat_q == $past(LED_ASSERT_EQUATION & sel_q);
   endproperty
   a_trip_latch: assert property (p_trip_latch) else $error("trip latch wrong");

   property p_new_trip;
      s_trip_taken |=> (lat_q & ~$past(LED_ASSERT_EQUATION)) == 6'h00;
   endproperty
   a_new_trip: assert property (p_new_trip) else $error("old targets kept on new trip");

   property p_reset_keep;
      s_reset_taken |=> lat_q == $past(lat_q & LED_ASSERT_EQUATION);
   endproperty
   a_reset_keep: assert property (p_reset_keep) else $error("reset result wrong");

   property p_enabled;
      !btn_s_q |=> LED_OUT.enabled == $past(SELF_TEST_OK);
   endproperty
   a_enabled: assert property (p_enabled) else $error("enabled indicator wrong");

   property p_lamp;
      btn_s_q |=> LED_OUT == '1;
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp test not all on");

   property p_msg;
      s_reset_taken ##0 !TRIP_IN |=> !msg_q ##1 !TRIP_MSG;
   endproperty
   a_msg: assert property (p_msg) else $error("trip message not cleared");

   property p_trip_led;
      TRIP_IN && !btn_s_q |=> LED_OUT.trip;
   endproperty
   a_trip_led: assert property (p_trip_led) else $error("trip indicator dark on trip");

   property p_flash;
      !btn_s_q && !TRIP_IN && !trip_lat_q |=> LED_OUT.trip == $past(warn_q & blink_q);
   endproperty
   a_flash: assert property (p_flash) else $error("warning flash wrong");

   property p_interval;
      !tick |=> $stable(lat_q) && $stable(asrt_q);
   endproperty
   a_interval: assert property (p_interval) else $error("latch moved between ticks");

   property p_pair;
      ##1 1'b1 |-> DISP_PAIR == $past(row[2*pair_q +: 2]);
   endproperty
   a_pair: assert property (p_pair) else $error("display pair mismatch");
endmodule
`default_nettype wire

// file: tll_partner.sv
// model of the operator pushbutton and the protection trip logic
`default_nettype none
module tll_partner (
   input  wire logic          clk,
   output var  logic [5:0]    eq,
   output var  logic          trip,
   output var  logic          btn,
   output var  logic          rst_eq,
   output var  tll_pkg::tll_warn_t warn
);
   timeunit 1ns;
   timeprecision 100ps;
   import tll_pkg::*;
   // quiet panel and healthy plant at power up
   initial begin
      eq = 6'h00;
      trip = 1'b0;
      btn = 1'b0;
      rst_eq = 1'b0;
      warn = '0;
   end
   // whole processing intervals
   task automatic ticks(input int n);
      repeat (n * PROC_CYC) @(posedge clk);
   endtask
   // trip level held over two intervals so a tick always sees the rise
   task automatic fault(input logic [5:0] e);
      @(posedge clk);
      eq <= e;
      trip <= 1'b1;
      ticks(2);
      trip <= 1'b0;
      ticks(2);
   endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the target indicator block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import tll_pkg::*;
   typedef struct packed { logic [31:0] e; logic [31:0] m; } tll_exp_t;
   logic        mclk, rstn, cyc, stb, we, ack, self_ok, msg, irq, t0;
   logic [7:0]  adr, row;
   logic [31:0] wdat, rdat;
   logic [5:0]  eq, r;
   logic        trip, btn, rst_eq;
   logic [1:0]  pair;
   logic [3:0]  sel;
   tll_warn_t   warn;
   tll_led_t    led;
   tll_exp_t    expq[$];
   tll_exp_t    x;
   int          mismatches = 0;
   int          n_compared = 0;
   int          v;
   tll_target_leds #(.BLINK_LEN(4)) tll_target_leds_i (.MCLK(mclk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .LED_ASSERT_EQUATION(eq), .TRIP_IN(trip), .SELF_TEST_OK(self_ok), .WARN_IN(warn),
      .TARGET_RESET_EQUATION(rst_eq), .RESET_BUTTON(btn), .LED_OUT(led), .TRIP_MSG(msg), .DISP_PAIR(pair), .IRQ(irq));
   tll_partner tll_partner_i (.clk(mclk), .eq(eq), .trip(trip), .btn(btn), .rst_eq(rst_eq), .warn(warn));
   // free-running 200 MHz clock
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      n_compared++;
      if (got !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   // read results are matched against the oldest note as each ack appears
   always @(posedge mclk) begin
      if (ack === 1'b1 && expq.size() > 0) begin
         x = expq.pop_front();
         if (x.m != 32'h0) chk(rdat & x.m, x.e);
      end
   end
   // one classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m);
      int n;
      n = 0;
      expq.push_back('{e: e & m, m: m});
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) chk({31'h0, ack}, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      wb(1'b0, a, 32'h0, e, m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 32'h0, 32'h0);
   endtask
   task automatic tk(input int n);
      repeat (n * PROC_CYC) @(posedge mclk);
   endtask
   // let registered outputs settle, then look between edges
   task automatic settle;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard, far beyond the roughly 16000 cycles the tests need
   initial begin
      repeat (80000) @(posedge mclk);
      mismatches++;
      stop_test();
   end
   // main sequence
   initial begin
      rstn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      sel = 4'hF;
      self_ok = 1'b1;
      void'($urandom(32'h171DCC25));
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      tk(2);
      rd(OFS_CFG, {18'h0, RST_WARN_EN, 2'h0, RST_LATCH_SEL}, 32'h3F3F);
      rd(OFS_IMASK, {29'h0, RST_IMASK}, 32'h7);
      rd(8'h1C, 32'h0, 32'hFFFFFFFF);
      rd(OFS_STAT, 32'h080, 32'h3FF);
      done("reset");
      // lane 0 only: latch selects change, warning enables on lane 1 must not
      sel <= 4'h1;
      wr(OFS_CFG, 32'h0000_0000);
      sel <= 4'hF;
      rd(OFS_CFG, {18'h0, RST_WARN_EN, 8'h00}, 32'h3F3F);
      wr(OFS_CFG, 32'h3F00);
      for (int i = 0; i < 4; i++) begin
         r = 6'($urandom);
         row = {2'b10, r};
         tll_partner_i.eq <= r;
         wr(OFS_VIEW, 32'(i));
         tk(2);
         rd(OFS_STAT, {24'h0, row}, 32'hFF);
         rd(OFS_VIEW, {20'h0, 2'(row >> (2 * i)), 2'(i), row}, 32'hFFF);
         chk({30'h0, pair}, {30'h0, 2'(row >> (2 * i))});
      end
      done("follow");
      wr(OFS_CFG, 32'h3F3F);
      tll_partner_i.eq <= 6'h02;
      tk(2);
      rd(OFS_STAT, 32'h080, 32'h3FF);
      tll_partner_i.fault(6'h02);
      rd(OFS_STAT, 32'h2C2, 32'h3FF);
      chk({31'h0, msg}, 32'h1);
      tll_partner_i.eq <= 6'h00;
      tk(2);
      rd(OFS_STAT, 32'h2C2, 32'h3FF);
      tll_partner_i.fault(6'h04);
      rd(OFS_STAT, 32'h2C4, 32'h3FF);
      rd(OFS_ISTAT, 32'h1, 32'h1);
      wr(OFS_CMD, 32'h1);
      tk(2);
      rd(OFS_STAT, 32'h04, 32'h3F);
      tll_partner_i.eq <= 6'h00;
      wr(OFS_CMD, 32'h1);
      tk(2);
      rd(OFS_STAT, 32'h080, 32'h3FF);
      chk({31'h0, msg}, 32'h0);
      rd(OFS_ISTAT, 32'h4, 32'h4);
      tll_partner_i.fault(6'h01);
      tll_partner_i.eq <= 6'h00;
      tll_partner_i.rst_eq <= 1'b1;
      tk(2);
      tll_partner_i.rst_eq <= 1'b0;
      rd(OFS_STAT, 32'h080, 32'h3FF);
      done("latch");
      tll_partner_i.fault(6'h08);
      tll_partner_i.btn <= 1'b1;
      settle();
      chk(32'(led), 32'hFF);
      tk(1);
      chk(32'(led), 32'hFF);
      @(posedge mclk);
      tll_partner_i.btn <= 1'b0;
      tk(2);
      rd(OFS_STAT, 32'h08, 32'h3F);
      tll_partner_i.eq <= 6'h00;
      tll_partner_i.btn <= 1'b1;
      // press spans whole intervals so a tick sees it before the release
      tk(2);
      tll_partner_i.btn <= 1'b0;
      tk(2);
      rd(OFS_STAT, 32'h080, 32'h3FF);
      done("lamp");
      wr(OFS_IMASK, 32'h0);
      for (int i = 0; i < 9; i++) begin
         tll_partner_i.warn <= 9'(1 << i);
         tk(2);
         rd(OFS_STAT, 32'h100, 32'h100);
      end
      settle();
      chk({31'h0, irq}, 32'h0);
      @(posedge mclk);
      wr(OFS_IMASK, 32'h2);
      settle();
      chk({31'h0, irq}, 32'h1);
      v = 0;
      t0 = led.trip;
      for (int k = 0; k < 12 * PROC_CYC; k++) begin
         @(posedge mclk);
         if (led.trip !== t0) v++;
         t0 = led.trip;
      end
      chk(32'(v >= 2), 32'h1);
      wr(OFS_ISTAT, 32'h2);
      settle();
      chk({31'h0, irq}, 32'h0);
      @(posedge mclk);
      wr(OFS_CFG, 32'h003F);
      tk(2);
      rd(OFS_STAT, 32'h0, 32'h100);
      tll_partner_i.warn <= '0;
      self_ok <= 1'b0;
      tk(2);
      settle();
      chk({31'h0, led.enabled}, 32'h0);
      done("warning");
      stop_test();
   end
endmodule
`default_nettype wire
